// [common/dsd_pkg.sv]
// package for the data space decoder: address map, timing and carriers
// assumes a single core clock and a synchronous active-low reset
package dsd_pkg;
  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [15:0] DSD_REGFILE_LAST = 16'h001F;
  localparam logic [15:0] DSD_STDIO_FIRST = 16'h0020;
  localparam logic [15:0] DSD_STDIO_LAST = 16'h005F;
  localparam logic [15:0] DSD_EXTIO_FIRST = 16'h0060;
  localparam logic [15:0] DSD_EXTIO_LAST = 16'h00FF;
  localparam logic [15:0] DSD_SRAM_FIRST = 16'h0100;
  localparam logic [15:0] DSD_SRAM_LAST = 16'h08FF;
  localparam int DSD_SRAM_BYTES = 2048;
  localparam logic [7:0] DSD_IO_OFFSET = 8'h20;
  localparam logic [5:0] DSD_DISP_MAX = 6'h3F;
  // ----------------------------------------
  // nonvolatile store registers (short i/o addresses)
  // ----------------------------------------
  localparam logic [5:0] DSD_NV_CTRL_ADDR = 6'h1F;
  localparam logic [5:0] DSD_NV_DATA_ADDR = 6'h20;
  localparam logic [5:0] DSD_NV_ADRL_ADDR = 6'h21;
  localparam logic [5:0] DSD_NV_ADRH_ADDR = 6'h22;
  localparam int DSD_NV_BYTES = 1024;
  localparam int DSD_CTRL_ARM_BIT = 2;
  localparam int DSD_CTRL_STROBE_BIT = 1;
  localparam int DSD_CTRL_READ_BIT = 0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam logic [2:0] DSD_ARM_CYCLES = 3'h4;
  localparam logic [2:0] DSD_NV_READ_STALL = 3'h4;
  localparam logic [2:0] DSD_NV_WRITE_STALL = 3'h2;
  localparam logic [2:0] DSD_SRAM_STALL = 3'h1;
  localparam int DSD_CLK_MHZ = 125;
  localparam int DSD_NV_WRITE_US = 3400;
  localparam int DSD_NV_WRITE_CYCLES = DSD_NV_WRITE_US * DSD_CLK_MHZ;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef enum logic [2:0] {
    DSD_MODE_DIRECT,
    DSD_MODE_DISP,
    DSD_MODE_INDIRECT,
    DSD_MODE_PREDEC,
    DSD_MODE_POSTINC
  } dsd_mode_type;
  typedef enum logic [1:0] {
    DSD_PTR_X,
    DSD_PTR_Y,
    DSD_PTR_Z
  } dsd_ptr_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic short_io;
    dsd_mode_type mode;
    dsd_ptr_type ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dsd_req_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dsd_reg_acc_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsd_io_acc_type;
endpackage

// [hdl/dsd_decoder.sv]
// data space decoder: splits core load/store and short i/o accesses into
// register file, standard i/o, extended i/o, sram and nonvolatile store
// assumes the core holds a request stable while stall_out is high
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RL1 - 0x0000..0x001F goes to working registers
// RL2 - 0x0020..0x005F is standard i/o space
// RL3 - 0x0060..0x00FF is extended i/o space
// RL4 - extended i/o only by load and store
// RL5 - sram from 0x0100 up to 0x08FF
// RL6 - direct addressing reaches whole data space
// RL7 - displacement up to 63 on Y/Z
// RL8 - R26..R31 pointers, predecrement and postincrement
// RL9 - every mode reaches every region
// RL10 - sram access takes two core clocks
// RL11 - nonvolatile store, separate bytewide space
// RL12 - nonvolatile registers sit in i/o space
// RL13 - self-timed write with pollable busy flag
// RL14 - writes need the arming sequence first
// RL15 - nonvolatile read stalls core four cycles
// RL16 - nonvolatile write stalls core two cycles
// RL17 - reset does not abort a running write
// RL18 - short i/o 0x00..0x3F plus 0x20
// RL19 - arm bit self-clears after four cycles
// RL20 - above sram: writes ignored, reads zero
module dsd_decoder #(
  parameter int NV_WRITE_CYCLES = dsd_pkg::DSD_NV_WRITE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire dsd_pkg::dsd_req_type req_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic [7:0] io_rdata_in,
  output dsd_pkg::dsd_reg_acc_type reg_acc_out,
  output dsd_pkg::dsd_io_acc_type io_acc_out,
  output logic [7:0] rdata_out,
  output logic stall_out,
  output logic nv_busy_out
);
  import dsd_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] ptr_low(input dsd_ptr_type p);
    case (p)
      DSD_PTR_X: ptr_low = 5'h1A;
      DSD_PTR_Y: ptr_low = 5'h1C;
      default: ptr_low = 5'h1E;
    endcase
  endfunction

  function automatic logic [1:0] ptr_slot(input logic [4:0] r);
    ptr_slot = r[2:1] - 2'h1;
  endfunction

  function automatic logic [10:0] sram_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - DSD_SRAM_FIRST;
    sram_index = d[10:0];
  endfunction

  // ----------------------------------------
  // pointer shadow registers (R26..R31) and effective address
  // ----------------------------------------
  logic [15:0] ptr_reg [3];
  logic [15:0] base;
  logic [15:0] eff_addr;
  logic [15:0] ptr_next;
  logic req_go;

  always_comb begin
    base = ptr_reg[req_in.ptr];
    ptr_next = base;
    eff_addr = req_in.addr;
    if (req_in.short_io) begin
      eff_addr = {10'h000, req_in.addr[5:0]} + {8'h00, DSD_IO_OFFSET}; // see RL18
    end else begin
      case (req_in.mode)
        DSD_MODE_DIRECT: eff_addr = req_in.addr; // see RL6
        DSD_MODE_DISP: eff_addr = base + {10'h000, req_in.disp & DSD_DISP_MAX}; // see RL7
        DSD_MODE_INDIRECT: eff_addr = base;
        DSD_MODE_PREDEC: begin
          eff_addr = base - 16'h0001; // see RL8
          ptr_next = eff_addr;
        end
        DSD_MODE_POSTINC: begin
          eff_addr = base;
          ptr_next = base + 16'h0001; // see RL8
        end
        default: eff_addr = req_in.addr;
      endcase
    end
  end

  // ----------------------------------------
  // region decode; all modes share it
  // ----------------------------------------
  logic hit_reg, hit_io, hit_sram, hit_none;
  logic is_nv_reg;
  logic [7:0] io_addr;

  always_comb begin
    hit_reg = 1'b0;
    hit_io = 1'b0;
    hit_sram = 1'b0;
    hit_none = 1'b0;
    if (eff_addr <= DSD_REGFILE_LAST) begin
      hit_reg = 1'b1; // see RL1, RL9
    end else if (eff_addr <= DSD_STDIO_LAST) begin
      hit_io = 1'b1; // see RL2
    end else if (eff_addr <= DSD_EXTIO_LAST) begin
      hit_io = !req_in.short_io; // see RL3, RL4
      hit_none = req_in.short_io;
    end else if (eff_addr <= DSD_SRAM_LAST) begin
      hit_sram = 1'b1; // see RL5
    end else begin
      hit_none = 1'b1; // see RL20
    end
  end

  // short i/o view of the data address; the store's regs sit at 0x1F..0x22 there
  assign io_addr = eff_addr[7:0] - DSD_IO_OFFSET; // see RL18
  assign is_nv_reg = hit_io && (io_addr >= {2'h0, DSD_NV_CTRL_ADDR}) // see RL12
    && (io_addr <= {2'h0, DSD_NV_ADRH_ADDR});

  // ----------------------------------------
  // stall sequencing
  // ----------------------------------------
  logic [2:0] stall_reg;
  logic busy_go;
  logic nv_rd_start, nv_wr_start;
  logic [2:0] stall_need;

  // nothing is taken while reset is low, so no stray write starts then
  assign req_go = rst_n_in && req_in.valid && stall_reg == 3'h0;

  always_comb begin
    stall_need = 3'h0;
    if (hit_sram) begin
      stall_need = DSD_SRAM_STALL; // see RL10
    end else if (nv_rd_start) begin
      stall_need = DSD_NV_READ_STALL; // see RL15
    end else if (nv_wr_start) begin
      stall_need = DSD_NV_WRITE_STALL; // see RL16
    end
  end

  assign stall_out = (req_go && stall_need != 3'h0) || stall_reg > 3'h1;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      stall_reg <= 3'h0;
    end else if (req_go) begin
      stall_reg <= stall_need;
    end else if (stall_reg != 3'h0) begin
      stall_reg <= stall_reg - 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ptr_reg[0] <= 16'h0000;
      ptr_reg[1] <= 16'h0000;
      ptr_reg[2] <= 16'h0000;
    end else if (req_go) begin
      if (!req_in.short_io) begin
        ptr_reg[req_in.ptr] <= ptr_next;
      end
      // direct writes to R26..R31 keep the shadow pairs in step; see RL8
      if (hit_reg && req_in.write && eff_addr[4:0] >= ptr_low(DSD_PTR_X)) begin
        if (eff_addr[0]) begin
          ptr_reg[ptr_slot(eff_addr[4:0])][15:8] <= req_in.wdata;
        end else begin
          ptr_reg[ptr_slot(eff_addr[4:0])][7:0] <= req_in.wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // nonvolatile store registers
  // ----------------------------------------
  logic [7:0] nv_mem [DSD_NV_BYTES];
  logic [9:0] nv_addr_reg;
  logic [7:0] nv_data_reg;
  logic arm_reg;
  logic [2:0] arm_cnt_reg;
  logic nv_busy_reg;
  logic [31:0] nv_cnt_reg;
  logic [9:0] nv_waddr_reg;
  logic [7:0] nv_wdata_reg;
  logic nv_wr;
  logic ctrl_wr;

  assign nv_wr = req_go && req_in.write && is_nv_reg;
  assign ctrl_wr = nv_wr && io_addr[5:0] == DSD_NV_CTRL_ADDR;
  assign nv_rd_start = ctrl_wr && req_in.wdata[DSD_CTRL_READ_BIT] && !nv_busy_reg;
  // strobe honoured only while arm still set; see RL14, RL19
  assign nv_wr_start = ctrl_wr && req_in.wdata[DSD_CTRL_STROBE_BIT] && arm_reg
    && !nv_busy_reg;
  assign nv_busy_out = nv_busy_reg; // see RL13

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      arm_reg <= 1'b0;
      arm_cnt_reg <= 3'h0;
    end else if (ctrl_wr && req_in.wdata[DSD_CTRL_ARM_BIT]) begin
      arm_reg <= 1'b1;
      arm_cnt_reg <= DSD_ARM_CYCLES;
    end else if (arm_cnt_reg != 3'h0) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
      arm_reg <= arm_cnt_reg != 3'h1; // see RL19
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      nv_addr_reg <= 10'h000;
      nv_data_reg <= 8'h00;
    end else begin
      if (nv_wr && io_addr[5:0] == DSD_NV_ADRL_ADDR) begin
        nv_addr_reg[7:0] <= req_in.wdata;
      end
      if (nv_wr && io_addr[5:0] == DSD_NV_ADRH_ADDR) begin
        nv_addr_reg[9:8] <= req_in.wdata[1:0];
      end
      if (nv_wr && io_addr[5:0] == DSD_NV_DATA_ADDR) begin
        nv_data_reg <= req_in.wdata;
      end else if (nv_rd_start) begin
        nv_data_reg <= nv_mem[nv_addr_reg]; // see RL11
      end
    end
  end

  // no reset here: a write under way finishes through reset; see RL17
  always_ff @(posedge ref_clk_in) begin
    if (nv_wr_start) begin
      nv_busy_reg <= 1'b1;
      nv_cnt_reg <= 32'(NV_WRITE_CYCLES);
      nv_waddr_reg <= nv_addr_reg;
      nv_wdata_reg <= nv_data_reg;
    end else if (nv_busy_reg === 1'b1 && nv_cnt_reg > 32'h0000_0001) begin
      nv_cnt_reg <= nv_cnt_reg - 32'h0000_0001;
    end else begin
      if (nv_busy_reg === 1'b1) begin
        nv_mem[nv_waddr_reg] <= nv_wdata_reg;
      end
      nv_busy_reg <= 1'b0;
      nv_cnt_reg <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // sram array and read data
  // ----------------------------------------
  logic [7:0] sram_mem [DSD_SRAM_BYTES];
  logic [7:0] rdata_reg;

  always_ff @(posedge ref_clk_in) begin
    if (req_go && hit_sram && req_in.write) begin
      sram_mem[sram_index(eff_addr)] <= req_in.wdata;
    end
  end

  logic [7:0] nv_rd_mux;
  always_comb begin
    if (io_addr[5:0] == DSD_NV_CTRL_ADDR) begin
      nv_rd_mux = {6'h00, nv_busy_reg === 1'b1, 1'b0} | {5'h00, arm_reg, 2'h0};
    end else if (io_addr[5:0] == DSD_NV_DATA_ADDR) begin
      nv_rd_mux = nv_data_reg;
    end else if (io_addr[5:0] == DSD_NV_ADRL_ADDR) begin
      nv_rd_mux = nv_addr_reg[7:0];
    end else begin
      nv_rd_mux = {6'h00, nv_addr_reg[9:8]};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else if (req_go && !req_in.write) begin
      if (hit_reg) begin
        rdata_reg <= reg_rdata_in;
      end else if (is_nv_reg) begin
        rdata_reg <= nv_rd_mux;
      end else if (hit_io) begin
        rdata_reg <= io_rdata_in;
      end else if (hit_sram) begin
        rdata_reg <= sram_mem[sram_index(eff_addr)];
      end else begin
        rdata_reg <= 8'h00; // see RL20
      end
    end
  end
  assign rdata_out = rdata_reg;

  // ----------------------------------------
  // register file and peripheral strobes
  // ----------------------------------------
  always_comb begin
    reg_acc_out.valid = req_go && hit_reg;
    reg_acc_out.write = req_in.write;
    reg_acc_out.addr = eff_addr[4:0];
    reg_acc_out.wdata = req_in.wdata;
    io_acc_out.valid = req_go && hit_io && !is_nv_reg;
    io_acc_out.write = req_in.write;
    io_acc_out.addr = eff_addr[7:0];
    io_acc_out.wdata = req_in.wdata;
  end
  logic unused_hit;
  assign unused_hit = hit_none;
endmodule
`default_nettype wire

// [verif/dsd_far_model.sv]
// far-side model: register file and peripheral registers behind the decoder
// assumes the decoder's access pulses qualify every write
`timescale 1ns/1ns
`default_nettype none
module dsd_far_model
  import dsd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire dsd_pkg::dsd_reg_acc_type reg_acc_in,
  input wire dsd_pkg::dsd_io_acc_type io_acc_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] io_rdata_out
);
  logic [7:0] reg_mem [32];
  logic [7:0] io_mem [256];
  // ----------------------------------------
  // storage and read lines
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reg_acc_in.valid && reg_acc_in.write) begin
      reg_mem[reg_acc_in.addr] <= reg_acc_in.wdata;
    end
    if (io_acc_in.valid && io_acc_in.write) begin
      io_mem[io_acc_in.addr] <= io_acc_in.wdata;
    end
  end
  // unselected lines show the inverse so a stale byte never passes
  assign reg_rdata_out = reg_acc_in.valid ? reg_mem[reg_acc_in.addr] : ~reg_mem[reg_acc_in.addr];
  assign io_rdata_out = io_acc_in.valid ? io_mem[io_acc_in.addr] : ~io_mem[io_acc_in.addr];
endmodule
`default_nettype wire

// [verif/dsd_decoder_properties.sv]
// port checker for the data space decoder
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder_properties
  import dsd_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire dsd_pkg::dsd_req_type req_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic [7:0] io_rdata_in,
  input wire dsd_pkg::dsd_reg_acc_type reg_acc_out,
  input wire dsd_pkg::dsd_io_acc_type io_acc_out,
  input wire logic [7:0] rdata_out,
  input wire logic stall_out,
  input wire logic nv_busy_out
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic direct;
  assign direct = req_in.valid && !req_in.short_io && req_in.mode == DSD_MODE_DIRECT;
  regfile_route_a: assert property (
    direct && req_in.addr <= DSD_REGFILE_LAST && reg_acc_out.valid
    |-> reg_acc_out.addr == req_in.addr[4:0] && reg_acc_out.write == req_in.write)
    else $error("register access mismatch");
  io_route_a: assert property (
    direct && req_in.addr >= DSD_STDIO_FIRST && req_in.addr <= DSD_EXTIO_LAST
    |-> !reg_acc_out.valid && (!io_acc_out.valid || io_acc_out.addr == req_in.addr[7:0]))
    else $error("io access mismatch");
  short_offset_a: assert property (
    req_in.valid && req_in.short_io && io_acc_out.valid
    |-> io_acc_out.addr == {2'h0, req_in.addr[5:0]} + DSD_IO_OFFSET)
    else $error("short io offset wrong");
  sram_stall_a: assert property (
    $rose(req_in.valid) && direct && req_in.addr >= DSD_SRAM_FIRST
    && req_in.addr <= DSD_SRAM_LAST |-> stall_out ##1 !stall_out)
    else $error("sram stall length wrong");
  nv_read_stall_a: assert property (
    $rose(req_in.valid) && req_in.short_io && req_in.write && req_in.wdata == 8'h01
    && req_in.addr[5:0] == DSD_NV_CTRL_ADDR && nv_busy_out == 1'b0
    |-> stall_out [*4] ##1 !stall_out)
    else $error("read stall length wrong");
  high_read_zero_a: assert property (
    $rose(req_in.valid) && direct && !req_in.write && req_in.addr > DSD_SRAM_LAST
    |-> ##1 rdata_out == 8'h00)
    else $error("read above sram not zero");
  reg_read_data_a: assert property (
    $rose(req_in.valid) && direct && !req_in.write && req_in.addr <= DSD_REGFILE_LAST
    |-> ##1 rdata_out == $past(reg_rdata_in))
    else $error("register read data wrong");
  busy_hold_a: assert property (
    $rose(nv_busy_out) |-> nv_busy_out [*8])
    else $error("busy dropped early");
  stall_bound_a: assert property (
    stall_out |-> ##[1:4] !stall_out)
    else $error("stall too long");
endmodule
bind dsd_decoder dsd_decoder_properties #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_props (
  .ref_clk_in, .rst_n_in, .req_in, .reg_rdata_in, .io_rdata_in, .reg_acc_out,
  .io_acc_out, .rdata_out, .stall_out, .nv_busy_out);
`default_nettype wire

// [verif/test_data_space_decoder.sv]
// self-checking bench for the data space decoder
// assumes the far-side model answers register and peripheral reads
`timescale 1ns/1ns
`default_nettype none
module test_data_space_decoder;
  import dsd_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  dsd_req_type req_in = '0;
  logic [7:0] reg_rdata, io_rdata, rdata, rd_v;
  dsd_reg_acc_type reg_acc;
  dsd_io_acc_type io_acc;
  logic stall, nv_busy;
  int n_errors = 0;
  int n_checks = 0;
  int st_n;
  // short write time keeps the run brief
  dsd_decoder #(.NV_WRITE_CYCLES(20)) i_dut (.ref_clk_in, .rst_n_in, .req_in,
    .reg_rdata_in(reg_rdata), .io_rdata_in(io_rdata), .reg_acc_out(reg_acc),
    .io_acc_out(io_acc), .rdata_out(rdata), .stall_out(stall), .nv_busy_out(nv_busy));
  dsd_far_model i_far (.ref_clk_in, .reg_acc_in(reg_acc), .io_acc_in(io_acc),
    .reg_rdata_out(reg_rdata), .io_rdata_out(io_rdata));
  always #4 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  // ws is {write, short}; request held until the stall has run out
  task automatic acc(input logic [1:0] ws, input dsd_mode_type m, input dsd_ptr_type p,
      input logic [5:0] d, input logic [15:0] a, input logic [7:0] wd);
    @(posedge ref_clk_in);
    #1;
    req_in = '{1'b1, ws[1], ws[0], m, p, d, a, wd};
    #1;
    st_n = 0;
    while (stall === 1'b1 && st_n < 9) begin
      @(posedge ref_clk_in);
      #1;
      st_n++;
    end
    @(posedge ref_clk_in);
    #1;
    rd_v = rdata;
    req_in.valid = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(2'h2, DSD_MODE_DIRECT, DSD_PTR_X, 6'h0, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    acc(2'h0, DSD_MODE_DIRECT, DSD_PTR_X, 6'h0, a, 8'h00);
  endtask
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    acc(2'h3, DSD_MODE_DIRECT, DSD_PTR_X, 6'h0, {10'h000, a}, d);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regions;
    wr(16'h0005, 8'h11);
    chk("reg 5", 8'h11, i_far.reg_mem[5]);
    wr(16'h005F, 8'h22);
    chk("std io top", 8'h22, i_far.io_mem[8'h5F]);
    io_wr(6'h10, 8'h33);
    chk("short io", 8'h33, i_far.io_mem[8'h30]);
    wr(16'h00FF, 8'h44);
    chk("ext io top", 8'h44, i_far.io_mem[8'hFF]);
    rd(16'h0005);
    chk("reg 5 read", 8'h11, rd_v);
  endtask
  task automatic t_sram;
    wr(DSD_SRAM_FIRST, 8'hA5);
    chk("sram stall", 8'h01, 8'(st_n));
    wr(DSD_SRAM_LAST, 8'h5A);
    wr(16'h0900, 8'hFF);
    rd(DSD_SRAM_LAST);
    chk("sram top", 8'h5A, rd_v);
    rd(16'h0900);
    chk("above sram", 8'h00, rd_v);
  endtask
  task automatic t_pointers;
    wr(16'h0101, 8'h3C);
    wr(16'h001A, 8'h00);
    wr(16'h001B, 8'h01);
    wr(16'h001C, 8'h00);
    wr(16'h001D, 8'h01);
    wr(16'h001E, 8'hC1);
    wr(16'h001F, 8'h00);
    acc(2'h0, DSD_MODE_POSTINC, DSD_PTR_X, 6'h0, 16'h0000, 8'h00);
    chk("postinc", 8'hA5, rd_v);
    acc(2'h0, DSD_MODE_INDIRECT, DSD_PTR_X, 6'h0, 16'h0000, 8'h00);
    chk("indirect", 8'h3C, rd_v);
    acc(2'h0, DSD_MODE_PREDEC, DSD_PTR_X, 6'h0, 16'h0000, 8'h00);
    chk("predec", 8'hA5, rd_v);
    acc(2'h0, DSD_MODE_DISP, DSD_PTR_Y, 6'h1, 16'h0000, 8'h00);
    chk("disp y", 8'h3C, rd_v);
    acc(2'h0, DSD_MODE_DISP, DSD_PTR_Z, DSD_DISP_MAX, 16'h0000, 8'h00);
    chk("disp z max", 8'hA5, rd_v);
  endtask
  task automatic t_nv;
    io_wr(DSD_NV_ADRL_ADDR, 8'h05);
    io_wr(DSD_NV_ADRH_ADDR, 8'h03);
    io_wr(DSD_NV_DATA_ADDR, 8'h3C);
    io_wr(DSD_NV_CTRL_ADDR, 8'h04);
    io_wr(DSD_NV_CTRL_ADDR, 8'h02);
    chk("write stall", 8'h02, 8'(st_n));
    chk("busy", 8'h01, {7'h0, nv_busy});
    rst_n_in = 1'b0;
    @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    chk("busy through reset", 8'h01, {7'h0, nv_busy});
    chk("rdata reset", 8'h00, rdata);
    st_n = 0;
    while (nv_busy !== 1'b0 && st_n < 100) begin
      @(posedge ref_clk_in);
      st_n++;
    end
    chk("busy done", 8'h00, {7'h0, nv_busy});
    io_wr(DSD_NV_DATA_ADDR, 8'h00);
    io_wr(DSD_NV_CTRL_ADDR, 8'h02);
    chk("strobe unarmed", 8'h00, {7'h0, nv_busy});
    io_wr(DSD_NV_CTRL_ADDR, 8'h04);
    repeat (4) @(posedge ref_clk_in);
    io_wr(DSD_NV_CTRL_ADDR, 8'h02);
    chk("arm expired", 8'h00, {7'h0, nv_busy});
    io_wr(DSD_NV_ADRL_ADDR, 8'h05);
    io_wr(DSD_NV_ADRH_ADDR, 8'h03);
    io_wr(DSD_NV_CTRL_ADDR, 8'h01);
    chk("read stall", 8'h04, 8'(st_n));
    acc(2'h1, DSD_MODE_DIRECT, DSD_PTR_X, 6'h0, {10'h000, DSD_NV_DATA_ADDR}, 8'h00);
    chk("nv data", 8'h3C, rd_v);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_regions();
    t_sram();
    t_pointers();
    t_nv();
    complete_run();
  end
endmodule
`default_nettype wire
